// ===== design/bxp_pkg.sv
// Constants and types for the balance execute/pause/status block
package bxp_pkg;
    localparam int          CLK_MHZ         = 125;
    localparam int          START_DELAY_US  = 2000;  // start_delay_time, 2 ms
    localparam int          START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
    localparam int          CNT_W           = 20;
    localparam logic [4:0]  CMD_PREFIX      = 5'h15;  // 10101
    localparam logic [1:0]  SEL_WRITE       = 2'h0;
    localparam logic [1:0]  SEL_READBACK    = 2'h1;
    localparam logic [1:0]  SEL_STATUS      = 2'h2;
    localparam logic [1:0]  SEL_EXECUTE     = 2'h3;
    localparam logic [15:0] STATUS_RESET    = 16'h000F;
    localparam logic [3:0]  CRC_SEED        = 4'h0;
    localparam logic [3:0]  CRC_POLY_LOW    = 4'h3;   // x+1 taps of x^4+x+1
    localparam logic [3:0]  BIT_LAST        = 4'h7;
    localparam logic [3:0]  WORD_LAST       = 4'hF;

    // Command byte fields, MSB first
    typedef struct packed {
        logic [4:0] prefix;
        logic       cmd_select_hi;
        logic       cmd_select_lo;
        logic       parity;
    } bxp_cmd_t;

    // Analog health inputs
    typedef struct packed {
        logic [5:0] gate_drive_ok;
        logic       cells_below_overvolt;
        logic       secondary_below_overvolt;
        logic       temp_ok;
    } bxp_health_t;
endpackage

// ===== design/bxp_exec.sv
// Serial command interpreter for execute, pause, resume and status read
`timescale 1ns/1ns
module bxp_exec
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // Serial link pins
    input  wire logic                 chain_select_in,
    input  wire logic                 chain_clock_in,
    input  wire logic                 sdi,
    output logic                      sdo,
    // Latched command from the write path and analog health flags
    input  wire logic [11:0]          latched_cmd,
    input  wire logic                 latched_valid,
    input  wire bxp_pkg::bxp_health_t health,
    // Balancer drive, pause flag and status word
    output logic [11:0]               active_cmd,
    output logic                      paused,
    output logic [15:0]               status_word
);
    // Synchroniser stages
    logic [1:0] cs_s;
    logic [1:0] ck_s;
    logic [1:0] di_s;
    logic       ck_d;              // Previous synced clock
    logic       cs_d;              // Previous synced select
    logic [7:0] shreg;             // Incoming command byte
    logic [3:0] bit_cnt;           // Bits of current byte
    logic       byte_done;         // Command byte already taken
    logic       ignore;            // Rest of frame discarded
    logic       streaming;         // Status shifting
    logic [15:0] out_sh;           // Outgoing status shift
    logic [11:0] exec_cmd;         // Executed command
    logic [bxp_pkg::CNT_W-1:0] dly_cnt; // Start delay counter
    logic       armed;             // Delay has elapsed
    logic       rise;
    logic       fall;
    logic       cs_fall;
    logic [7:0] next_byte;
    bxp_pkg::bxp_cmd_t cmd;
    logic [11:0] msg;

    // CRC over the twelve message bits, result inverted
    function automatic logic [3:0] crc4(input logic [11:0] m);
        logic [3:0] c;
        logic       fb;
        c = bxp_pkg::CRC_SEED;
        for (int i = 11; i >= 0; i--)
        begin
            fb = c[3] ^ m[i];
            c  = {c[2:0], 1'b0} ^ (fb ? bxp_pkg::CRC_POLY_LOW : 4'h0);
        end
        return ~c;
    endfunction

    // Edge detect on synced pins
    assign rise      = ck_s[1] & ~ck_d;
    assign fall      = ~ck_s[1] & ck_d;
    assign cs_fall   = ~cs_s[1] & cs_d;
    assign next_byte = {shreg[6:0], di_s[1]};
    assign cmd       = bxp_pkg::bxp_cmd_t'(next_byte);

    // Two-flop synchronisers for link pins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cs_s <= 2'h3;
            ck_s <= 2'h0;
            di_s <= 2'h0;
            ck_d <= 1'b0;
            cs_d <= 1'b1;
        end
        else
        begin
            cs_s <= {cs_s[0], chain_select_in};
            ck_s <= {ck_s[0], chain_clock_in};
            di_s <= {di_s[0], sdi};
            ck_d <= ck_s[1];
            cs_d <= cs_s[1];
        end
    end

    // Command byte reception and decode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shreg     <= 8'h00;
            bit_cnt   <= 4'h0;
            byte_done <= 1'b0;
            ignore    <= 1'b0;
            streaming <= 1'b0;
            paused    <= 1'b0;
            exec_cmd  <= 12'h000;
        end
        else if (cs_s[1] || cs_fall)
        begin
            // Deselect or new frame: ready for next byte
            bit_cnt   <= 4'h0;
            byte_done <= 1'b0;
            ignore    <= 1'b0;
            streaming <= 1'b0;
        end
        else if (rise && !byte_done && !ignore)
        begin
            shreg   <= next_byte;
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == bxp_pkg::BIT_LAST)
            begin
                byte_done <= 1'b1;
                // Good parity: even count of ones over the whole byte
                if (^next_byte[7:1] != cmd.parity)
                begin
                    // Wrong parity pauses, whatever the other bits hold
                    paused <= 1'b1;
                    ignore <= 1'b1;
                end
                else if (cmd.prefix != bxp_pkg::CMD_PREFIX)
                    ignore <= 1'b1;
                else if ({cmd.cmd_select_hi, cmd.cmd_select_lo}
                         == bxp_pkg::SEL_EXECUTE)
                begin
                    exec_cmd <= latched_valid ? latched_cmd : 12'h000;
                    paused   <= 1'b0;
                    ignore   <= 1'b1;
                end
                else if ({cmd.cmd_select_hi, cmd.cmd_select_lo}
                         == bxp_pkg::SEL_STATUS)
                    streaming <= 1'b1;
                else
                    ignore <= 1'b1;
            end
        end
    end

    // Start delay, restarted on every execute byte
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dly_cnt <= '0;
            armed   <= 1'b0;
        end
        else if (rise && !byte_done && !ignore && !cs_s[1] && !cs_fall
                 && bit_cnt == bxp_pkg::BIT_LAST
                 && cmd.prefix == bxp_pkg::CMD_PREFIX
                 && {cmd.cmd_select_hi, cmd.cmd_select_lo} == bxp_pkg::SEL_EXECUTE
                 && ^next_byte[7:1] == cmd.parity)
        begin
            dly_cnt <= bxp_pkg::CNT_W'(bxp_pkg::START_DELAY_CYC - 1);
            armed   <= 1'b0;
        end
        else if (dly_cnt != '0)
            dly_cnt <= dly_cnt - 1'b1;
        else
            armed <= 1'b1;
    end

    // Drive to balancers and status flags
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_cmd  <= 12'h000;
            status_word <= bxp_pkg::STATUS_RESET;
        end
        else
        begin
            active_cmd  <= (armed && !paused) ? exec_cmd : 12'h000;
            status_word <= {msg, crc4(msg)};
        end
    end

    // Status message: flags only for active balancers
    always_comb
    begin
        msg = 12'h000;
        for (int i = 0; i < 6; i++)
            msg[11-i] = health.gate_drive_ok[5-i]
                        & (active_cmd[11-2*i] | active_cmd[10-2*i]);
        if (active_cmd != 12'h000)
        begin
            msg[5] = health.cells_below_overvolt;
            msg[4] = health.secondary_below_overvolt;
            msg[3] = health.temp_ok;
        end
    end

    // Status output shifter, own word first then zeros
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_sh <= 16'h0000;
            sdo    <= 1'b0;
        end
        else if (!streaming)
        begin
            out_sh <= status_word;
            sdo    <= 1'b0;
        end
        else if (fall)
        begin
            sdo    <= out_sh[15];
            out_sh <= {out_sh[14:0], 1'b0};
        end
    end

    // Checks
    a_reset_status: assert property (
        @(posedge clk) $rose(rstn) |-> status_word == bxp_pkg::STATUS_RESET)
        else $error("status not reset value");
    a_pause_off: assert property (
        @(posedge clk) disable iff (!rstn) paused |=> active_cmd == 12'h000)
        else $error("active while paused");
    a_delay_gate: assert property (
        @(posedge clk) disable iff (!rstn) !armed |=> active_cmd == 12'h000)
        else $error("active before delay");
    a_crc_field: assert property (
        @(posedge clk) disable iff (!rstn)
        status_word[3:0] == crc4(status_word[15:4]))
        else $error("bad crc");
    a_zero_bits: assert property (
        @(posedge clk) disable iff (!rstn) status_word[6:4] == 3'h0)
        else $error("unused bits set");
    a_flag_gate: assert property (
        @(posedge clk) disable iff (!rstn)
        active_cmd == 12'h000 |=> status_word[15:7] == 9'h000)
        else $error("flag idle");
    a_ignore_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        ignore && !cs_s[1] && !cs_fall |=> $stable(bit_cnt))
        else $error("bits taken");
    a_resume_clear: assert property (
        @(posedge clk) disable iff (!rstn) $fell(paused) |-> dly_cnt != '0)
        else $error("no restart delay");
    c_pause: cover property (@(posedge clk) $rose(paused));
    c_resume: cover property (@(posedge clk) $fell(paused));
    c_active: cover property (@(posedge clk) active_cmd != 12'h000);
    c_stream: cover property (@(posedge clk) $rose(streaming));
endmodule

// ===== tb/bxp_host.sv
// Host-side serial master model for the balance execute/pause/status block
`timescale 1ns/1ns
module bxp_host
(
    // Core clock used for pacing
    input  wire logic clk,
    // Serial link
    output logic      chain_select_in,
    output logic      chain_clock_in,
    output logic      sdi,
    input  wire logic sdo
);
    // Link idles deselected with its clock parked low
    initial
    begin
        chain_select_in = 1'b1;
        chain_clock_in  = 1'b0;
        sdi             = 1'b1;
    end

    // One frame: n bits of tx MSB first, 80 ns per bit, sdo taken before each rise
    task automatic frame(input logic [23:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        chain_select_in = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sdi = tx[23-i];
            repeat (5) @(negedge clk);
            rx = {rx[14:0], sdo};
            chain_clock_in = 1'b1;
            repeat (5) @(negedge clk);
            chain_clock_in = 1'b0;
        end
        chain_select_in = 1'b1;
        sdi = ~sdi;                          // Released line must not keep its value
        repeat (5) @(negedge clk);
    endtask
endmodule

// ===== tb/balance_execute_pause_status_test.sv
// Self-checking bench for the balance execute/pause/status block
`timescale 1ns/1ns
module balance_execute_pause_status_test;
    logic                 clk;              // Core clock, 8 ns
    logic                 rstn;             // Active-low reset
    logic                 chain_select_in;  // Serial select
    logic                 chain_clock_in;   // Serial clock
    logic                 sdi;              // Serial data in
    logic                 sdo;              // Serial data out
    logic [11:0]          latched_cmd;      // Latched balance message
    logic                 latched_valid;    // Latched message present
    bxp_pkg::bxp_health_t health;           // Analog health flags
    logic [11:0]          active_cmd;       // Balancer drive
    logic                 paused;           // Pause flag
    logic [15:0]          status_word;      // Status word
    logic [15:0]          rx;               // Word read back over the link
    logic [11:0]          msg;              // Expected status message
    int                   num_errors;       // Mismatches seen
    int                   total_checks;     // Comparisons made

    // Clock generator
    always #4 clk = ~clk;

    bxp_exec bxp_exec_i (.clk(clk), .rstn(rstn), .chain_select_in(chain_select_in),
        .chain_clock_in(chain_clock_in), .sdi(sdi), .sdo(sdo), .latched_cmd(latched_cmd),
        .latched_valid(latched_valid), .health(health), .active_cmd(active_cmd),
        .paused(paused), .status_word(status_word));

    bxp_host bxp_host_i (.clk(clk), .chain_select_in(chain_select_in),
        .chain_clock_in(chain_clock_in), .sdi(sdi), .sdo(sdo));

    // Status CRC: x^4+x+1 over twelve bits, sent inverted
    function automatic logic [3:0] crc4(input logic [11:0] m);
        logic [3:0] c;
        c = bxp_pkg::CRC_SEED;
        for (int i = 11; i >= 0; i--)
            c = {c[2:0], 1'b0} ^ ((c[3] ^ m[i]) ? bxp_pkg::CRC_POLY_LOW : 4'h0);
        return ~c;
    endfunction

    // Compare one value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Send one command byte and let the result settle; good parity is an even count of ones
    task automatic cmd(input logic [7:0] b);
        bxp_host_i.frame({b, 16'h0000}, 8, rx);
        repeat (10) @(negedge clk);
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog sized for two full start delays plus margin
    initial
    begin
        repeat (600000) @(posedge clk);
        num_errors++;
        summarize();
    end

    // Test sequence
    initial
    begin
        clk = 0; rstn = 0; num_errors = 0; total_checks = 0;
        latched_cmd = 12'h000; latched_valid = 0; health = '0;
        repeat (12) @(negedge clk);
        rstn = 1;
        repeat (5) @(negedge clk);
        chk(status_word, 16'h000F);
        chk({4'h0, active_cmd}, 16'h0000);
        bxp_host_i.frame({8'hAC, 16'h0000}, 24, rx);
        chk(rx, 16'h000F);
        $display("test reset done");
        cmd(8'h2E);
        chk({15'h0, paused}, 16'h0000);
        cmd(8'hAE);
        chk({15'h0, paused}, 16'h0001);
        cmd(8'hAF);
        chk({15'h0, paused}, 16'h0000);
        cmd(8'hAD);
        chk({15'h0, paused}, 16'h0001);
        cmd(8'hAF);
        chk({15'h0, paused}, 16'h0000);
        cmd(8'h2F);
        chk({15'h0, paused}, 16'h0001);
        cmd(8'hAF);
        chk({15'h0, paused}, 16'h0000);
        $display("test pause done");
        latched_cmd = 12'hA5C; latched_valid = 1; health = '1;
        bxp_host_i.frame({8'hAF, 8'hAE, 8'h00}, 16, rx);
        repeat (10) @(negedge clk);
        chk({15'h0, paused}, 16'h0000);
        repeat (249800) @(negedge clk);
        chk({4'h0, active_cmd}, 16'h0000);
        repeat (300) @(negedge clk);
        chk({4'h0, active_cmd}, 16'h0A5C);
        msg = 12'b111110_111_000;
        bxp_host_i.frame({8'hAC, 16'h0000}, 24, rx);
        chk(rx, {msg, crc4(msg)});
        chk(status_word, {msg, crc4(msg)});
        $display("test execute done");
        cmd(8'hAE);
        chk({3'h0, paused, active_cmd}, 16'h1000);
        cmd(8'hAF);
        chk({15'h0, paused}, 16'h0000);
        repeat (249900) @(negedge clk);
        chk({4'h0, active_cmd}, 16'h0000);
        repeat (300) @(negedge clk);
        chk({4'h0, active_cmd}, 16'h0A5C);
        $display("test resume done");
        summarize();
    end
endmodule
